// *** hw/tccb_bank.sv ***
// Transceiver channel control bank with AXI4-Lite slave and config mailbox
// Summary of operation
// - Postcursor field bits 4:0, reset zero, driven
// - Precursor code saturates at twenty units
// - Swing code sixteen monotonic steps, passed through
// - Swing register resets zero, drives channel
// - Loopback three-bit field decoded, reset normal
// - Transmit reset bit holds until cleared
// - Receive reset bit holds until cleared
// - Two-bit transmit power state, reset normal
// - Inhibit forces positive low, negative high
// - Transmit invert swaps serial line sense
// - Receive invert flips incoming serial data
// - Mailbox reaches common and channel spaces
// - Accesses wait for channel domain crossing
`timescale 1ns/1ns
`default_nettype none
module tccb_bank #(
    parameter int NUM_CH  = 4,
    parameter int NUM_COM = 1,
    parameter int CFG_AW  = 10
) (
    input  wire logic                          sys_clk,
    input  wire logic                          rst_n,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [11:0]                   s_axi_awaddr,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    output logic [1:0]                         s_axi_bresp,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    input  wire logic [11:0]                   s_axi_araddr,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output tccb_pkg::tccb_chan_s [NUM_CH-1:0]  chan_ctrl,
    input  wire logic [NUM_CH-1:0]             tx_serial_bit,
    output logic [NUM_CH-1:0]                  serial_out_pos,
    output logic [NUM_CH-1:0]                  serial_out_neg,
    input  wire logic [NUM_CH-1:0]             rx_line_pos,
    output logic [NUM_CH-1:0]                  rx_serial_bit,
    output logic                               cfg_req,
    output logic                               cfg_we,
    output logic                               cfg_common,
    output logic [7:0]                         cfg_index,
    output logic [CFG_AW-1:0]                  cfg_addr,
    output logic [15:0]                        cfg_wdata,
    output logic                               cfg_port_reset,
    input  wire logic                          cfg_rdy,
    input  wire logic [15:0]                   cfg_rdata
);
    typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_RESP} tccb_state_e;

    tccb_state_e                state_ff;
    logic                       is_wr_ff;
    logic [11:0]                addr_ff;
    logic [31:0]                wdata_ff;
    logic [3:0]                 wstrb_ff;
    logic [2:0]                 xfer_cnt_ff;
    logic [31:0]                rdata_ff;
    logic [1:0]                 resp_ff;
    logic [7:0]                 ch_sel_ff;
    logic [7:0]                 com_sel_ff;
    tccb_pkg::tccb_chan_s       ctrl_ff [NUM_CH];
    logic [29:0]                mbx_addr_ff;
    logic [15:0]                mbx_wdata_ff;
    logic [15:0]                mbx_rdata_ff;
    logic                       mbx_busy_ff;
    logic                       mbx_type_ff;
    logic                       mbx_com_ff;
    logic                       take_wr;
    logic                       take_rd;
    logic                       xfer_done;
    logic                       ch_ok;
    logic                       mapped;
    logic [31:0]                cur_val;
    logic [31:0]                nxt_val;
    logic [31:0]                strb_mask;
    tccb_pkg::tccb_chan_s       sel;
    logic                       mbx_page;
    logic                       mbx_start;

    // Handshake: a write needs address and data together, writes win ties
    assign take_wr       = (state_ff == ST_IDLE) && s_axi_awvalid && s_axi_wvalid;
    assign take_rd       = (state_ff == ST_IDLE) && s_axi_arvalid && !take_wr;
    assign s_axi_awready = take_wr;
    assign s_axi_wready  = take_wr;
    assign s_axi_arready = take_rd;
    assign s_axi_bvalid  = (state_ff == ST_RESP) && is_wr_ff;
    assign s_axi_rvalid  = (state_ff == ST_RESP) && !is_wr_ff;
    assign s_axi_bresp   = resp_ff;
    assign s_axi_rresp   = resp_ff;
    assign s_axi_rdata   = rdata_ff;
    assign xfer_done     = (state_ff == ST_XFER) && (xfer_cnt_ff == 3'(tccb_pkg::XFER_CYC - 1));

    // Transaction sequencer
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            state_ff    <= ST_IDLE;
            is_wr_ff    <= 1'b0;
            addr_ff     <= 12'h000;
            wdata_ff    <= 32'h0000_0000;
            wstrb_ff    <= 4'h0;
            xfer_cnt_ff <= 3'h0;
        end
        else
        begin
            case (state_ff)
                ST_IDLE:
                begin
                    xfer_cnt_ff <= 3'h0;
                    if (take_wr)
                    begin
                        state_ff <= ST_XFER;
                        is_wr_ff <= 1'b1;
                        addr_ff  <= {s_axi_awaddr[11:2], 2'b00};
                        wdata_ff <= s_axi_wdata;
                        wstrb_ff <= s_axi_wstrb;
                    end
                    else if (take_rd)
                    begin
                        state_ff <= ST_XFER;
                        is_wr_ff <= 1'b0;
                        addr_ff  <= {s_axi_araddr[11:2], 2'b00};
                    end
                end
                ST_XFER:
                begin
                    xfer_cnt_ff <= xfer_cnt_ff + 3'h1;
                    if (xfer_done)
                        state_ff <= ST_RESP;
                end
                ST_RESP:
                begin
                    if ((is_wr_ff && s_axi_bready) || (!is_wr_ff && s_axi_rready))
                        state_ff <= ST_IDLE;
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // Address decode and current read value of the addressed word
    always_comb
    begin
        ch_ok    = (ch_sel_ff < 8'(NUM_CH));
        sel      = ctrl_ff[ch_sel_ff[$clog2(NUM_CH)-1:0]];
        mbx_page = (addr_ff[11:8] == tccb_pkg::MBX_PAGE_COM) || (addr_ff[11:8] == tccb_pkg::MBX_PAGE_CH);
        mapped   = 1'b1;
        cur_val  = 32'h0000_0000;
        if (addr_ff == tccb_pkg::OFS_NUM_COM)
            cur_val = 32'(NUM_COM);
        else if (addr_ff == tccb_pkg::OFS_NUM_CH)
            cur_val = 32'(NUM_CH);
        else if (addr_ff == tccb_pkg::OFS_COM_SEL)
            cur_val = {24'h000000, com_sel_ff};
        else if (addr_ff == tccb_pkg::OFS_CH_SEL)
            cur_val = {24'h000000, ch_sel_ff};
        else if (addr_ff == tccb_pkg::OFS_POST_TAP)
            cur_val = {27'h0, sel.post_tap};
        else if (addr_ff == tccb_pkg::OFS_PRE_TAP)
            cur_val = {27'h0, sel.pre_tap};
        else if (addr_ff == tccb_pkg::OFS_LOOPBACK)
            cur_val = {29'h0, sel.loopback};
        else if (addr_ff == tccb_pkg::OFS_TX_RST)
            cur_val = {31'h0, sel.tx_system_reset};
        else if (addr_ff == tccb_pkg::OFS_RX_RST)
            cur_val = {31'h0, sel.rx_system_reset};
        else if (addr_ff == tccb_pkg::OFS_TX_PWR)
            cur_val = {30'h0, sel.tx_power_state};
        else if (addr_ff == tccb_pkg::OFS_SWING)
            cur_val = {28'h0, sel.swing};
        else if (addr_ff == tccb_pkg::OFS_INHIBIT)
            cur_val = {31'h0, sel.tx_output_inhibit};
        else if (addr_ff == tccb_pkg::OFS_TX_INV)
            cur_val = {31'h0, sel.tx_invert};
        else if (addr_ff == tccb_pkg::OFS_RX_INV)
            cur_val = {31'h0, sel.rx_invert};
        else if (mbx_page && addr_ff[7:0] == tccb_pkg::MBX_ADDR)
            cur_val = {2'b00, mbx_addr_ff};
        else if (mbx_page && addr_ff[7:0] == tccb_pkg::MBX_WDATA)
            cur_val = {16'h0000, mbx_wdata_ff};
        else if (mbx_page && addr_ff[7:0] == tccb_pkg::MBX_RDATA)
            cur_val = {16'h0000, mbx_rdata_ff};
        else if (mbx_page && addr_ff[7:0] == tccb_pkg::MBX_RESET)
            cur_val = 32'h0000_0000;
        else if (mbx_page && addr_ff[7:0] == tccb_pkg::MBX_STATUS)
            cur_val = {29'h0, mbx_busy_ff & mbx_type_ff, 1'b0, mbx_busy_ff};
        else
            mapped = 1'b0;
        // Channel registers of an out-of-range channel read zero
        if (addr_ff[11:10] == 2'b01 || addr_ff[11:8] == 4'h6)
            if (!ch_ok)
                cur_val = 32'h0000_0000;
        strb_mask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
        nxt_val   = (cur_val & ~strb_mask) | (wdata_ff & strb_mask);
    end

    // Response capture at the end of the crossing
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            rdata_ff <= 32'h0000_0000;
            resp_ff  <= tccb_pkg::RESP_OKAY;
        end
        else if (xfer_done)
        begin
            rdata_ff <= is_wr_ff ? 32'h0000_0000 : cur_val;
            resp_ff  <= mapped ? tccb_pkg::RESP_OKAY : tccb_pkg::RESP_SLVERR;
        end
    end

    // Index registers
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            ch_sel_ff  <= 8'h00;
            com_sel_ff <= 8'h00;
        end
        else if (xfer_done && is_wr_ff)
        begin
            if (addr_ff == tccb_pkg::OFS_CH_SEL)
                ch_sel_ff <= nxt_val[7:0];
            if (addr_ff == tccb_pkg::OFS_COM_SEL)
                com_sel_ff <= nxt_val[7:0];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        for (int i = 0; i < NUM_CH; i++)
        begin
            if (!rst_n)
                ctrl_ff[i] <= tccb_pkg::CHAN_RESET;
            else if (xfer_done && is_wr_ff && ch_ok && ch_sel_ff == 8'(i))
            begin
                if (addr_ff == tccb_pkg::OFS_POST_TAP) ctrl_ff[i].post_tap <= nxt_val[4:0];
                if (addr_ff == tccb_pkg::OFS_PRE_TAP)  ctrl_ff[i].pre_tap <= nxt_val[4:0];
                if (addr_ff == tccb_pkg::OFS_LOOPBACK) ctrl_ff[i].loopback <= nxt_val[2:0];
                if (addr_ff == tccb_pkg::OFS_TX_RST)   ctrl_ff[i].tx_system_reset <= nxt_val[0];
                if (addr_ff == tccb_pkg::OFS_RX_RST)   ctrl_ff[i].rx_system_reset <= nxt_val[0];
                if (addr_ff == tccb_pkg::OFS_TX_PWR)   ctrl_ff[i].tx_power_state <= nxt_val[1:0];
                if (addr_ff == tccb_pkg::OFS_SWING)    ctrl_ff[i].swing <= nxt_val[3:0];
                if (addr_ff == tccb_pkg::OFS_INHIBIT)  ctrl_ff[i].tx_output_inhibit <= nxt_val[0];
                if (addr_ff == tccb_pkg::OFS_TX_INV)   ctrl_ff[i].tx_invert <= nxt_val[0];
                if (addr_ff == tccb_pkg::OFS_RX_INV)   ctrl_ff[i].rx_invert <= nxt_val[0];
            end
        end
    end

    // mailbox start: exactly one of write or read flag
    assign mbx_start = xfer_done && is_wr_ff && mbx_page && addr_ff[7:0] == tccb_pkg::MBX_ADDR
                       && (nxt_val[tccb_pkg::MBX_WR_BIT] ^ nxt_val[tccb_pkg::MBX_RD_BIT]) && !mbx_busy_ff;

    // mailbox engine over common or channel space
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            mbx_addr_ff    <= 30'h0;
            mbx_wdata_ff   <= 16'h0000;
            mbx_rdata_ff   <= 16'h0000;
            mbx_busy_ff    <= 1'b0;
            mbx_type_ff    <= 1'b0;
            mbx_com_ff     <= 1'b0;
            cfg_req        <= 1'b0;
            cfg_port_reset <= 1'b0;
        end
        else
        begin
            cfg_req        <= mbx_start;
            cfg_port_reset <= xfer_done && is_wr_ff && mbx_page && addr_ff[7:0] == tccb_pkg::MBX_RESET
                              && nxt_val[0];
            if (xfer_done && is_wr_ff && mbx_page && addr_ff[7:0] == tccb_pkg::MBX_ADDR)
                mbx_addr_ff <= nxt_val[29:0];
            if (xfer_done && is_wr_ff && mbx_page && addr_ff[7:0] == tccb_pkg::MBX_WDATA)
                mbx_wdata_ff <= nxt_val[15:0];
            if (mbx_start)
            begin
                mbx_busy_ff <= 1'b1;
                mbx_type_ff <= nxt_val[tccb_pkg::MBX_WR_BIT];
                mbx_com_ff  <= (addr_ff[11:8] == tccb_pkg::MBX_PAGE_COM);
            end
            else if (mbx_busy_ff && (cfg_rdy || cfg_port_reset))
            begin
                mbx_busy_ff <= 1'b0;
                if (!mbx_type_ff && cfg_rdy)
                    mbx_rdata_ff <= cfg_rdata;
            end
        end
    end

    assign cfg_we     = mbx_type_ff;
    assign cfg_common = mbx_com_ff;
    assign cfg_index  = mbx_com_ff ? com_sel_ff : ch_sel_ff;
    assign cfg_addr   = mbx_addr_ff[CFG_AW-1:0];
    assign cfg_wdata  = mbx_wdata_ff;

    // Per-channel resync stage and serial line logic
    for (genvar g = 0; g < NUM_CH; g++)
    begin : g_chan
        tccb_pkg::tccb_chan_s stage_ff;
        tccb_pkg::tccb_chan_s shaped;

        // saturate precursor, reserved loopback treated as normal
        always_comb
        begin
            shaped = ctrl_ff[g];
            if (ctrl_ff[g].pre_tap > tccb_pkg::PRE_TAP_MAX)
                shaped.pre_tap = tccb_pkg::PRE_TAP_MAX;
            if (!(ctrl_ff[g].loopback inside {tccb_pkg::LB_NORMAL, tccb_pkg::LB_NEAR_PCS, tccb_pkg::LB_NEAR_PMA,
                                              tccb_pkg::LB_FAR_PMA, tccb_pkg::LB_FAR_PCS}))
                shaped.loopback = tccb_pkg::LB_NORMAL;
        end

        // two-stage resync, swing passed as is
        always_ff @(posedge sys_clk)
        begin
            if (!rst_n)
            begin
                stage_ff     <= tccb_pkg::CHAN_RESET;
                chan_ctrl[g] <= tccb_pkg::CHAN_RESET;
            end
            else
            begin
                stage_ff     <= shaped;
                chan_ctrl[g] <= stage_ff;
            end
        end

        always_ff @(posedge sys_clk)
        begin
            if (!rst_n)
            begin
                serial_out_pos[g] <= 1'b0;
                serial_out_neg[g] <= 1'b1;
                rx_serial_bit[g]  <= 1'b0;
            end
            else
            begin
                serial_out_pos[g] <= !chan_ctrl[g].tx_output_inhibit && (tx_serial_bit[g] ^ chan_ctrl[g].tx_invert);
                serial_out_neg[g] <= chan_ctrl[g].tx_output_inhibit || !(tx_serial_bit[g] ^ chan_ctrl[g].tx_invert);
                rx_serial_bit[g]  <= rx_line_pos[g] ^ chan_ctrl[g].rx_invert;
            end
        end

        a_inhibit_lines: assert property (@(posedge sys_clk) disable iff (!rst_n)
            $past(chan_ctrl[g].tx_output_inhibit) && $past(rst_n) |-> !serial_out_pos[g] && serial_out_neg[g])
            else $error("inhibit did not force line levels");
        a_tx_invert: assert property (@(posedge sys_clk) disable iff (!rst_n)
            $past(!chan_ctrl[g].tx_output_inhibit) && $past(rst_n)
            |-> serial_out_pos[g] == ($past(tx_serial_bit[g]) ^ $past(chan_ctrl[g].tx_invert)))
            else $error("transmit sense wrong");
        a_rx_invert: assert property (@(posedge sys_clk) disable iff (!rst_n)
            $past(rst_n) |-> rx_serial_bit[g] == ($past(rx_line_pos[g]) ^ $past(chan_ctrl[g].rx_invert)))
            else $error("receive sense wrong");
        a_pre_sat: assert property (@(posedge sys_clk) disable iff (!rst_n)
            chan_ctrl[g].pre_tap <= tccb_pkg::PRE_TAP_MAX)
            else $error("precursor not saturated");
        a_ctrl_resync: assert property (@(posedge sys_clk) disable iff (!rst_n)
            ##2 chan_ctrl[g].swing == $past(ctrl_ff[g].swing, 2) && chan_ctrl[g].post_tap == $past(ctrl_ff[g].post_tap, 2))
            else $error("channel copy not driven after two cycles");
    end

    a_xfer_delay: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (take_wr || take_rd) |=> (state_ff == ST_XFER) [*4] ##1 state_ff == ST_RESP)
        else $error("access did not wait for crossing");
    a_reset_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sel.tx_system_reset && !(xfer_done && is_wr_ff) |=> sel.tx_system_reset)
        else $error("transmit reset cleared itself");
    a_rx_reset_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sel.rx_system_reset && !(xfer_done && is_wr_ff) |=> sel.rx_system_reset)
        else $error("receive reset cleared itself");
    a_loop_legal: assert property (@(posedge sys_clk) disable iff (!rst_n)
        chan_ctrl[0].loopback != 3'h3 && chan_ctrl[0].loopback != 3'h5 && chan_ctrl[0].loopback != 3'h7)
        else $error("reserved loopback reached channel");
    a_mbx_req: assert property (@(posedge sys_clk) disable iff (!rst_n)
        mbx_start |=> cfg_req && mbx_busy_ff)
        else $error("mailbox did not start");
    c_write: cover property (@(posedge sys_clk) disable iff (!rst_n) take_wr ##5 s_axi_bvalid);
    c_read: cover property (@(posedge sys_clk) disable iff (!rst_n) take_rd ##5 s_axi_rvalid);
    c_mbx_done: cover property (@(posedge sys_clk) disable iff (!rst_n) mbx_busy_ff && cfg_rdy);
    c_inhibit: cover property (@(posedge sys_clk) disable iff (!rst_n) chan_ctrl[0].tx_output_inhibit);
endmodule : tccb_bank
`default_nettype wire

// *** hw/tccb_pkg.sv ***
// Package: register map, field layouts and timing for the channel control bank
package tccb_pkg;
    // Register byte offsets
    localparam logic [11:0] OFS_NUM_COM   = 12'h008;
    localparam logic [11:0] OFS_NUM_CH    = 12'h00C;
    localparam logic [11:0] OFS_COM_SEL   = 12'h020;
    localparam logic [11:0] OFS_CH_SEL    = 12'h024;
    localparam logic [11:0] OFS_POST_TAP  = 12'h414;
    localparam logic [11:0] OFS_PRE_TAP   = 12'h418;
    localparam logic [11:0] OFS_LOOPBACK  = 12'h41C;
    localparam logic [11:0] OFS_TX_RST    = 12'h420;
    localparam logic [11:0] OFS_RX_RST    = 12'h424;
    localparam logic [11:0] OFS_TX_PWR    = 12'h504;
    localparam logic [11:0] OFS_SWING     = 12'h508;
    localparam logic [11:0] OFS_INHIBIT   = 12'h50C;
    localparam logic [11:0] OFS_TX_INV    = 12'h510;
    localparam logic [11:0] OFS_RX_INV    = 12'h604;
    // Mailbox pages and offsets within a page
    localparam logic [3:0]  MBX_PAGE_COM  = 4'h1;
    localparam logic [3:0]  MBX_PAGE_CH   = 4'h2;
    localparam logic [7:0]  MBX_ADDR      = 8'h04;
    localparam logic [7:0]  MBX_WDATA     = 8'h08;
    localparam logic [7:0]  MBX_RDATA     = 8'h0C;
    localparam logic [7:0]  MBX_RESET     = 8'h10;
    localparam logic [7:0]  MBX_STATUS    = 8'h14;
    localparam int          MBX_WR_BIT    = 31;
    localparam int          MBX_RD_BIT    = 30;
    localparam int          STAT_BUSY_BIT = 0;
    localparam int          STAT_TYPE_BIT = 2;
    // Field codes
    localparam logic [4:0]  PRE_TAP_MAX   = 5'h14;
    localparam logic [2:0]  LB_NORMAL     = 3'h0;
    localparam logic [2:0]  LB_NEAR_PCS   = 3'h1;
    localparam logic [2:0]  LB_NEAR_PMA   = 3'h2;
    localparam logic [2:0]  LB_FAR_PMA    = 3'h4;
    localparam logic [2:0]  LB_FAR_PCS    = 3'h6;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    // Domain crossing time and its cycle count at 100 MHz
    localparam int          CLK_PERIOD_NS = 10;
    localparam int          XFER_NS       = 40;
    localparam int          XFER_CYC      = (XFER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // One channel's control settings
    typedef struct packed {
        logic [4:0] post_tap;
        logic [4:0] pre_tap;
        logic [3:0] swing;
        logic [2:0] loopback;
        logic       tx_system_reset;
        logic       rx_system_reset;
        logic [1:0] tx_power_state;
        logic       tx_output_inhibit;
        logic       tx_invert;
        logic       rx_invert;
    } tccb_chan_s;

    localparam tccb_chan_s CHAN_RESET = '0;
endpackage : tccb_pkg

// *** verif/tccb_cfg_model.sv ***
// Config port responder standing in for the transceiver channel
`timescale 1ns/1ns
`default_nettype none
module tccb_cfg_model #(parameter int AW = 10) (
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    input  wire logic          cfg_req,
    input  wire logic          cfg_we,
    input  wire logic [AW-1:0] cfg_addr,
    input  wire logic [15:0]   cfg_wdata,
    output logic               cfg_rdy,
    output logic [15:0]        cfg_rdata
);
    logic [2:0]    wait_ff;
    logic          wr_seen_ff;
    logic [AW-1:0] wr_addr_ff;
    logic [15:0]   wr_data_ff;
    // Answer three cycles after a request; data toggles when not valid; last write reads back
    always_ff @(posedge sys_clk)
    begin
        cfg_rdy <= 1'b0;
        cfg_rdata <= ~cfg_rdata;
        if (!rst_n) begin wait_ff <= 3'h0; cfg_rdata <= 16'h0; wr_seen_ff <= 1'b0; end
        else if (cfg_req)
        begin
            wait_ff <= 3'h3;
            if (cfg_we) begin wr_seen_ff <= 1'b1; wr_addr_ff <= cfg_addr; wr_data_ff <= cfg_wdata; end
        end
        else if (wait_ff != 3'h0)
        begin
            wait_ff <= wait_ff - 3'h1;
            if (wait_ff == 3'h1)
            begin
                cfg_rdy   <= 1'b1;
                cfg_rdata <= (wr_seen_ff && wr_addr_ff == cfg_addr) ? wr_data_ff : 16'hA500 ^ 16'(cfg_addr);
            end
        end
    end
endmodule : tccb_cfg_model
`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking bench for the channel control bank
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic sys_clk = 0, rst_n = 0, awv = 0, wv = 0, arv = 0;
    logic [11:0] awa = '0, ara = '0;
    logic [31:0] wd = '0, rdat;
    logic [3:0] txb = '0, rxl = '0, rxs, sp, sn;
    logic awr, wr_, bv, arr, rv, creq, crdy;
    logic [1:0] br, rr;
    logic [31:0] rd_w;
    logic [9:0] cad;
    logic [15:0] crd;
    logic cwe, ccom, cprst;
    logic [7:0] cidx;
    logic [15:0] cwd;
    int prst_count = 0;
    tccb_pkg::tccb_chan_s [3:0] cc;
    int fail_count = 0, total_checks = 0;
    always #5 sys_clk = ~sys_clk;
    tccb_bank u_tccb_bank (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
        .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(1'b1), .s_axi_rdata(rdat), .s_axi_rresp(rr),
        .chan_ctrl(cc), .tx_serial_bit(txb), .serial_out_pos(sp), .serial_out_neg(sn), .rx_line_pos(rxl),
        .rx_serial_bit(rxs), .cfg_req(creq), .cfg_we(cwe), .cfg_common(ccom), .cfg_index(cidx), .cfg_addr(cad),
        .cfg_wdata(cwd), .cfg_port_reset(cprst), .cfg_rdy(crdy), .cfg_rdata(crd));
    tccb_cfg_model u_tccb_cfg_model (.sys_clk(sys_clk), .rst_n(rst_n), .cfg_req(creq), .cfg_we(cwe),
        .cfg_addr(cad), .cfg_wdata(cwd), .cfg_rdy(crdy), .cfg_rdata(crd));
    // Count config port reset pulses
    always @(posedge sys_clk)
        if (cprst) prst_count <= prst_count + 1;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin fail_count++; $display("[ERR] %0t got %h exp %h", $time, got, exp); end
    endtask : chk
    // Bus write; hold request until ready, then wait for the answer
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] rs = 2'h0);
        int n = 0;
        awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1;
        do @(posedge sys_clk); while (awr !== 1'b1);
        chk(wr_, 1);
        awv <= 1'b0; wv <= 1'b0;
        do begin @(posedge sys_clk); n++; end while (bv !== 1'b1 && n < 50);
        chk(n, tccb_pkg::XFER_CYC + 1);
        chk(br, rs);
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        int n = 0;
        ara <= a; arv <= 1'b1;
        do @(posedge sys_clk); while (arr !== 1'b1);
        arv <= 1'b0;
        do begin @(posedge sys_clk); n++; end while (rv !== 1'b1 && n < 50);
        chk(n, tccb_pkg::XFER_CYC + 1);
        chk(rr, tccb_pkg::RESP_OKAY);
        d = rdat;
    endtask : rd
    task automatic t_reset();
        logic [11:0] ofs [9] = '{12'h414, 12'h41C, 12'h420, 12'h424, 12'h504, 12'h508, 12'h50C, 12'h510, 12'h604};
        foreach (ofs[i]) begin rd(ofs[i], rd_w); chk(rd_w, 0); end
        chk({31'h0, cc == '0}, 1);
        chk({sp, sn}, 8'h0F);
        $display("test reset done");
    endtask : t_reset
    task automatic t_fields();
        wr(12'h024, 2);
        wr(12'h414, 32'h15);
        wr(12'h418, 32'h1F);
        wr(12'h508, 32'hF);
        wr(12'h41C, 32'h6);
        wr(12'h420, 1);
        wr(12'h424, 1);
        wr(12'h504, 32'h3);
        repeat (20) @(posedge sys_clk);
        chk(cc[2], {5'h15, 5'h14, 4'hF, 3'h6, 1'b1, 1'b1, 2'h3, 3'h0});
        chk(cc[0], '0);
        rd(12'h418, rd_w); chk(rd_w, 32'h1F);
        wr(12'h418, 32'h13); wr(12'h420, 0); repeat (4) @(posedge sys_clk);
        chk(cc[2].pre_tap, 5'h13);
        chk(cc[2].tx_system_reset, 0);
        chk(cc[2].rx_system_reset, 1);
        $display("test fields done");
    endtask : t_fields
    task automatic t_serial();
        wr(12'h024, 1);
        wr(12'h50C, 1); txb <= 4'hF; repeat (4) @(posedge sys_clk);
        chk({sp[1], sn[1]}, 2'b01);
        wr(12'h50C, 0); wr(12'h510, 1); repeat (4) @(posedge sys_clk);
        chk({sp, sn}, 8'hD2);
        txb <= 4'h0; repeat (2) @(posedge sys_clk);
        chk({sp, sn}, 8'h2D);
        wr(12'h604, 1); rxl <= 4'h3; repeat (4) @(posedge sys_clk);
        chk(rxs, 4'h1);
        $display("test serial done");
    endtask : t_serial
    task automatic t_mbox();
        wr(12'h024, 3);
        wr(12'h204, 32'h4000_007C); repeat (12) @(posedge sys_clk);
        rd(12'h214, rd_w); chk(rd_w, 0);
        rd(12'h20C, rd_w); chk(rd_w, 32'hA57C);
        chk(cidx, 3);
        chk(ccom, 0);
        // Rate change: power down, rewrite divider by read-modify-write, power up, reset
        wr(12'h504, 32'h3);
        wr(12'h208, (rd_w & 32'hF8FF) | 32'h0200);
        wr(12'h204, 32'h8000_007C); repeat (12) @(posedge sys_clk);
        chk(cwe, 1);
        wr(12'h204, 32'h4000_007C); repeat (12) @(posedge sys_clk);
        rd(12'h20C, rd_w); chk(rd_w, 32'hA27C);
        wr(12'h504, 0); wr(12'h420, 1); wr(12'h420, 0);
        wr(12'h020, 0); wr(12'h104, 32'h4000_0011); repeat (12) @(posedge sys_clk);
        chk(ccom, 1);
        chk(cidx, 0);
        rd(12'h10C, rd_w); chk(rd_w, 32'hA511);
        wr(12'h210, 1); @(posedge sys_clk);
        chk(prst_count, 1);
        wr(12'h7F0, 1, tccb_pkg::RESP_SLVERR);
        $display("test mailbox done");
    endtask : t_mbox
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    // Watchdog well beyond the expected run length
    initial begin #200000; fail_count++; print_verdict(); end
    initial
    begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        t_reset(); t_fields(); t_serial(); t_mbox();
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
